/* File: core/adcc_pkg.sv */
/*
 * Shared constants for the converter control block: register offsets, control and
 * configuration bit positions, offset slot fields, resolution codes and bus states.
 * Assumes a 32-bit AHB-Lite bus with one aligned word per register.
 */
package adcc_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_DIFF = 8'h08;
    localparam logic [7:0] OFS_JSEQ = 8'h0c;
    localparam logic [7:0] OFS_SLOT0 = 8'h10;
    localparam logic [7:0] OFS_RRES = 8'h20;
    localparam logic [7:0] OFS_JRES0 = 8'h24;
    localparam logic [7:0] OFS_STAT = 8'h34;
    localparam logic [7:0] OFS_MASK = 8'h38;
    localparam int NUM_SLOTS = 4;
    localparam int NUM_RANKS = 4;
    // ----------------------------------------------------------------
    // control register bits
    // ----------------------------------------------------------------
    localparam int CTL_ON = 0;
    localparam int CTL_CAL = 1;
    localparam int CTL_RSTART = 2;
    localparam int CTL_JSTART = 3;
    localparam int CTL_RSTOP = 4;
    localparam int CTL_JSTOP = 5;
    localparam int CTL_DIS = 6;
    localparam int CTL_W = 7;
    localparam logic [CTL_W-1:0] CTL_RST = 7'h00;
    // ----------------------------------------------------------------
    // configuration register bits
    // ----------------------------------------------------------------
    localparam int CFG_ALIGN = 0;
    localparam int CFG_RES_LO = 1;
    localparam int CFG_ROVS = 3;
    localparam int CFG_JOVS = 4;
    localparam int CFG_W = 5;
    localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
    localparam logic [1:0] RES_12 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_8 = 2'h2;
    localparam logic [1:0] RES_6 = 2'h3;
    // ----------------------------------------------------------------
    // offset slot fields, status bits
    // ----------------------------------------------------------------
    localparam int SLOT_ON = 31;
    localparam int SLOT_CH_HI = 30;
    localparam int SLOT_CH_LO = 26;
    localparam int SLOT_VAL_HI = 11;
    localparam logic [31:0] SLOT_RST = 32'h0000_0000;
    localparam int ST_RDONE = 0;
    localparam int ST_JDONE = 1;
    localparam int ST_W = 2;
    localparam logic [ST_W-1:0] ST_RST = 2'h0;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    // ----------------------------------------------------------------
    // bus slave states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0001,
        BUS_WRITE = 4'b0010,
        BUS_RWAIT = 4'b0100,
        BUS_RDONE = 4'b1000
    } adcc_bus_type;
endpackage : adcc_pkg

/* File: core/adcc_result_fmt.sv */
/*
 * Result formatter: applies the per-channel offset, sign extension and alignment to
 * one raw conversion value. Purely combinational; the caller registers the result.
 * Assumes raw data arrive right-aligned at the programmed resolution.
 */
`timescale 1ns/1ns
`default_nettype none
module adcc_result_fmt import adcc_pkg::*; (
    input wire logic [15:0] raw,
    input wire logic [4:0] channel,
    input wire logic [1:0] resolution,
    input wire logic align_left,
    input wire logic oversample,
    input wire logic [31:0] slots [NUM_SLOTS],
    output logic [15:0] result
);
    function automatic logic [4:0] res_bits(input logic [1:0] res);
        unique case (res)
            RES_12: res_bits = 5'd12;
            RES_10: res_bits = 5'd10;
            RES_8: res_bits = 5'd8;
            default: res_bits = 5'd6;
        endcase
    endfunction : res_bits

    always_comb begin
        logic hit;
        logic [11:0] ofs;
        logic [4:0] bits;
        logic [4:0] sh;
        logic [4:0] width;
        logic [11:0] left12;
        logic [12:0] diff;
        logic [15:0] val;
        hit = 1'b0;
        ofs = 12'h000;
        width = 5'd0;
        left12 = 12'h000;
        diff = 13'h0000;
        val = 16'h0000;
        bits = res_bits(resolution);
        sh = 5'd12 - bits;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            // lowest matching slot wins
            if (!hit && slots[i][SLOT_ON] && slots[i][SLOT_CH_HI:SLOT_CH_LO] == channel) begin
                hit = 1'b1;
                ofs = slots[i][SLOT_VAL_HI:0];
            end
        end
        if (oversample) begin
            hit = 1'b0;
        end
        // subtract on left-aligned raw data
        left12 = 12'(raw[11:0] << sh);
        diff = {1'b0, left12} - {1'b0, ofs};
        if (hit) begin
            val = 16'($signed({{3{diff[12]}}, diff}) >>> sh);
        end else begin
            val = {4'h0, raw[11:0]};
        end
        width = bits + {4'h0, hit};
        if (oversample) begin
            result = raw;
        end else if (align_left) begin
            if (resolution == RES_6) begin
                result = 16'(val << (5'd8 - width));
            end else begin
                result = 16'(val << (5'd16 - width));
            end
        end else begin
            result = val;
        end
    end
endmodule : adcc_result_fmt
`default_nettype wire

/* File: core/adcc_ctrl.sv */
/*
 * Converter control block: AHB-Lite register slave holding control, configuration,
 * differential select, injected sequence and four offset slots; stores formatted
 * regular and injected results on conversion-done pulses while on; sticky event status with
 * mask and one level interrupt.
 * Assumes the converter core runs on hclk and gives one-cycle done pulses.
 */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - forbidden writes unblocked; writing zero to whole control register recovers
// - regular done while on stores the converted value into the regular result
// - injected done while on stores the value into that rank's injected result
// - alignment bit picks right or left justification
// - left justification fills the half-word, or the byte at 6-bit
// - oversampling forces right justification
// - four offset slots: enable, 5-bit channel, 12-bit value subtracted
// - offset results are signed with sign extended upward
// - oversampling disables every offset slot
module adcc_ctrl import adcc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic regular_done,
    input wire logic [4:0] regular_channel,
    input wire logic [15:0] regular_data,
    input wire logic injected_conversion_done,
    input wire logic [1:0] injected_rank,
    input wire logic [4:0] injected_channel,
    input wire logic [15:0] injected_data,
    output logic converter_on,
    output logic calibrate_trigger,
    output logic regular_start,
    output logic injected_start,
    output logic regular_stop,
    output logic injected_stop,
    output logic disable_request,
    output logic [15:0] differential_select,
    output logic irq
);
    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    adcc_bus_type bus_ff, nxt_bus;
    logic [7:0] addr_ff, nxt_addr;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic hreadyout_ff, nxt_hreadyout;
    logic accept;
    logic [31:0] rd_word;
    logic wr_hit;

    assign accept = hsel && htrans[1] && hready;
    assign wr_hit = (bus_ff == BUS_WRITE);

    always_comb begin
        nxt_bus = BUS_IDLE;
        nxt_addr = addr_ff;
        nxt_hrdata = hrdata_ff;
        nxt_hreadyout = 1'b1;
        unique case (bus_ff)
            BUS_RWAIT: begin
                // one wait state so a preceding write is visible
                nxt_hrdata = rd_word;
                nxt_bus = BUS_RDONE;
            end
            BUS_IDLE, BUS_WRITE, BUS_RDONE: begin
                if (accept) begin
                    nxt_addr = haddr[7:0];
                    nxt_bus = hwrite ? BUS_WRITE : BUS_RWAIT;
                    nxt_hreadyout = hwrite;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_ff <= BUS_IDLE;
            addr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
        end else begin
            bus_ff <= nxt_bus;
            addr_ff <= nxt_addr;
            hrdata_ff <= nxt_hrdata;
            hreadyout_ff <= nxt_hreadyout;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;

    // ----------------------------------------------------------------
    // registers and result storage
    // ----------------------------------------------------------------
    logic [CTL_W-1:0] ctl_ff, nxt_ctl;
    logic [CFG_W-1:0] cfg_ff, nxt_cfg;
    logic [15:0] diff_ff, nxt_diff;
    logic [31:0] jseq_ff, nxt_jseq;
    logic [31:0] slot_ff [NUM_SLOTS];
    logic [31:0] nxt_slot [NUM_SLOTS];
    logic [15:0] rres_ff, nxt_rres;
    logic [15:0] jres_ff [NUM_RANKS];
    logic [15:0] nxt_jres [NUM_RANKS];
    logic [ST_W-1:0] stat_ff, nxt_stat;
    logic [ST_W-1:0] mask_ff, nxt_mask;
    logic irq_ff, nxt_irq;
    logic [15:0] fmt_reg, fmt_inj;
    logic ovs;

    assign ovs = cfg_ff[CFG_ROVS] || cfg_ff[CFG_JOVS];

    adcc_result_fmt u_fmt_reg (
        .raw(regular_data),
        .channel(regular_channel),
        .resolution(cfg_ff[CFG_RES_LO+1:CFG_RES_LO]),
        .align_left(cfg_ff[CFG_ALIGN]),
        .oversample(ovs),
        .slots(slot_ff),
        .result(fmt_reg)
    );

    adcc_result_fmt u_fmt_inj (
        .raw(injected_data),
        .channel(injected_channel),
        .resolution(cfg_ff[CFG_RES_LO+1:CFG_RES_LO]),
        .align_left(cfg_ff[CFG_ALIGN]),
        .oversample(ovs),
        .slots(slot_ff),
        .result(fmt_inj)
    );

    always_comb begin
        rd_word = 32'h0000_0000;
        if (addr_ff == OFS_CTRL) rd_word = 32'(ctl_ff);
        if (addr_ff == OFS_CFG) rd_word = 32'(cfg_ff);
        if (addr_ff == OFS_DIFF) rd_word = 32'(diff_ff);
        if (addr_ff == OFS_JSEQ) rd_word = jseq_ff;
        if (addr_ff == OFS_RRES) rd_word = 32'(rres_ff);
        if (addr_ff == OFS_STAT) rd_word = 32'(stat_ff);
        if (addr_ff == OFS_MASK) rd_word = 32'(mask_ff);
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (addr_ff == OFS_SLOT0 + 8'(4 * i)) rd_word = slot_ff[i];
            if (addr_ff == OFS_JRES0 + 8'(4 * i)) rd_word = 32'(jres_ff[i]);
        end
    end

    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_cfg = cfg_ff;
        nxt_diff = diff_ff;
        nxt_jseq = jseq_ff;
        nxt_slot = slot_ff;
        nxt_rres = rres_ff;
        nxt_jres = jres_ff;
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        // hardware completion of one-cycle requests
        nxt_ctl[CTL_CAL] = 1'b0;
        if (ctl_ff[CTL_RSTOP]) begin
            nxt_ctl[CTL_RSTART] = 1'b0;
            nxt_ctl[CTL_RSTOP] = 1'b0;
        end
        if (ctl_ff[CTL_JSTOP]) begin
            nxt_ctl[CTL_JSTART] = 1'b0;
            nxt_ctl[CTL_JSTOP] = 1'b0;
        end
        if (ctl_ff[CTL_DIS]) begin
            nxt_ctl = CTL_RST;
        end
        if (wr_hit) begin
            // writes are not checked against the current state
            if (addr_ff == OFS_CTRL) begin
                if (hwdata[CTL_W-1:0] == CTL_RST) begin
                    nxt_ctl = CTL_RST;
                end else begin
                    nxt_ctl[CTL_ON] = hwdata[CTL_ON];
                    nxt_ctl[CTL_CAL] = hwdata[CTL_CAL];
                    nxt_ctl[CTL_RSTART] = ctl_ff[CTL_RSTART] | hwdata[CTL_RSTART];
                    nxt_ctl[CTL_JSTART] = ctl_ff[CTL_JSTART] | hwdata[CTL_JSTART];
                    nxt_ctl[CTL_RSTOP] = hwdata[CTL_RSTOP];
                    nxt_ctl[CTL_JSTOP] = hwdata[CTL_JSTOP];
                    nxt_ctl[CTL_DIS] = hwdata[CTL_DIS];
                end
            end
            if (addr_ff == OFS_CFG) nxt_cfg = hwdata[CFG_W-1:0];
            if (addr_ff == OFS_DIFF) nxt_diff = hwdata[15:0];
            if (addr_ff == OFS_JSEQ) nxt_jseq = hwdata;
            if (addr_ff == OFS_MASK) nxt_mask = hwdata[ST_W-1:0];
            if (addr_ff == OFS_STAT) nxt_stat = stat_ff & ~hwdata[ST_W-1:0];
            for (int i = 0; i < NUM_SLOTS; i++) begin
                if (addr_ff == OFS_SLOT0 + 8'(4 * i)) begin
                    nxt_slot[i] = {hwdata[SLOT_ON:SLOT_CH_LO], 14'h0000, hwdata[SLOT_VAL_HI:0]};
                end
            end
        end
        // events win over a clear in the same cycle
        if (regular_done && ctl_ff[CTL_ON]) begin
            nxt_rres = fmt_reg;
            nxt_stat[ST_RDONE] = 1'b1;
        end
        if (injected_conversion_done && ctl_ff[CTL_ON]) begin
            nxt_jres[injected_rank] = fmt_inj;
            nxt_stat[ST_JDONE] = 1'b1;
        end
        nxt_irq = |(nxt_stat & nxt_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_ff <= CTL_RST;
            cfg_ff <= CFG_RST;
            diff_ff <= 16'h0000;
            jseq_ff <= 32'h0000_0000;
            rres_ff <= RESULT_RST;
            stat_ff <= ST_RST;
            mask_ff <= ST_RST;
            irq_ff <= 1'b0;
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_ff[i] <= SLOT_RST;
                jres_ff[i] <= RESULT_RST;
            end
        end else begin
            ctl_ff <= nxt_ctl;
            cfg_ff <= nxt_cfg;
            diff_ff <= nxt_diff;
            jseq_ff <= nxt_jseq;
            rres_ff <= nxt_rres;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
            slot_ff <= nxt_slot;
            jres_ff <= nxt_jres;
        end
    end

    assign converter_on = ctl_ff[CTL_ON];
    assign calibrate_trigger = ctl_ff[CTL_CAL];
    assign regular_start = ctl_ff[CTL_RSTART];
    assign injected_start = ctl_ff[CTL_JSTART];
    assign regular_stop = ctl_ff[CTL_RSTOP];
    assign injected_stop = ctl_ff[CTL_JSTOP];
    assign disable_request = ctl_ff[CTL_DIS];
    assign differential_select = diff_ff;
    assign irq = irq_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic no_slot;
    logic [12:0] chk_diff;
    assign no_slot = !(slot_ff[0][SLOT_ON] || slot_ff[1][SLOT_ON] || slot_ff[2][SLOT_ON] || slot_ff[3][SLOT_ON]);
    assign chk_diff = {1'b0, regular_data[11:0]} - {1'b0, slot_ff[0][SLOT_VAL_HI:0]};

    reg_store_a: assert property (
        regular_done && converter_on |=> rres_ff == $past(fmt_reg) && stat_ff[ST_RDONE])
        else $error("regular result not stored");
    inj_store_a: assert property (
        injected_conversion_done && converter_on |=> jres_ff[$past(injected_rank)] == $past(fmt_inj))
        else $error("injected result not stored in its rank");
    right_align_a: assert property (
        regular_done && converter_on && !ovs && no_slot && !cfg_ff[CFG_ALIGN] && cfg_ff[2:1] == RES_12
        |=> rres_ff == {4'h0, $past(regular_data[11:0])})
        else $error("right aligned result wrong");
    left_align_a: assert property (
        regular_done && converter_on && !ovs && no_slot && cfg_ff[CFG_ALIGN] && cfg_ff[2:1] == RES_12
        |=> rres_ff == {$past(regular_data[11:0]), 4'h0})
        else $error("left aligned half-word result wrong");
    byte_align_a: assert property (
        regular_done && converter_on && !ovs && no_slot && cfg_ff[CFG_ALIGN] && cfg_ff[2:1] == RES_6
        |=> rres_ff == {8'h00, $past(regular_data[5:0]), 2'h0})
        else $error("left aligned byte result wrong");
    ovs_right_a: assert property (
        regular_done && converter_on && ovs |=> rres_ff == $past(regular_data))
        else $error("oversampled result altered");
    offset_sign_a: assert property (
        regular_done && converter_on && !ovs && slot_ff[0][SLOT_ON] && !cfg_ff[CFG_ALIGN]
        && cfg_ff[2:1] == RES_12 && slot_ff[0][SLOT_CH_HI:SLOT_CH_LO] == regular_channel
        |=> rres_ff == $past({{3{chk_diff[12]}}, chk_diff}))
        else $error("offset subtraction or sign extension wrong");
    irq_level_a: assert property (
        irq == |(stat_ff & mask_ff))
        else $error("interrupt does not follow masked status");
    read_wait_a: assert property (
        accept && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout && hrdata == $past(rd_word))
        else $error("read answer timing wrong");
    dis_clear_a: assert property (
        disable_request |=> ctl_ff == CTL_RST || $past(wr_hit))
        else $error("disable request did not clear control");

    offset_c: cover property (regular_done && converter_on && !no_slot && !ovs);
    inj_c: cover property (injected_conversion_done && converter_on ##1 irq);
    read_c: cover property (accept && !hwrite ##2 hreadyout);
endmodule : adcc_ctrl
`default_nettype wire

/* File: tb/tb_adcc_ctrl.sv */
/*
 * Self-checking bench for the converter control block: register access over AHB-Lite,
 * control bit side effects, result formatting with offsets and the event interrupt.
 * Assumes zero-wait writes, one-wait reads and done pulses on hclk.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_adcc_ctrl import adcc_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire hready = hreadyout;
    logic regular_done, injected_conversion_done;
    logic [4:0] regular_channel, injected_channel;
    logic [15:0] regular_data, injected_data, differential_select;
    logic [1:0] injected_rank;
    logic converter_on, calibrate_trigger, regular_start, injected_start;
    logic regular_stop, injected_stop, disable_request;
    wire [6:0] ctl_o = {disable_request, injected_stop, regular_stop, injected_start,
                        regular_start, calibrate_trigger, converter_on};
    int mismatches, compares;
    // cfg, channel, raw data, expected result
    logic [47:0] tv [10] = '{48'h00_04_0abc_0abc, 48'h01_04_0abc_abc0, 48'h07_04_002a_00a8,
        48'h09_04_1234_1234, 48'h00_03_00ff_ffff, 48'h00_03_0200_0100,
        48'h01_03_00ff_fff8, 48'h10_03_00ff_00ff, 48'h05_04_00ab_ab00, 48'h02_05_00ff_ffff};

    adcc_ctrl uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .regular_done, .regular_channel,
        .regular_data, .injected_conversion_done, .injected_rank, .injected_channel,
        .injected_data, .converter_on, .calibrate_trigger, .regular_start,
        .injected_start, .regular_stop, .injected_stop, .disable_request,
        .differential_select, .irq);

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        check(name, x, exp);
    endtask : rd_chk

    task automatic conv(input logic inj, input logic [4:0] ch, input logic [15:0] d,
                        input logic [1:0] rk);
        @(posedge hclk);
        regular_done <= !inj;
        injected_conversion_done <= inj;
        regular_channel <= ch;
        injected_channel <= ch;
        regular_data <= d;
        injected_data <= d;
        injected_rank <= rk;
        @(posedge hclk);
        regular_done <= 1'b0;
        injected_conversion_done <= 1'b0;
    endtask : conv

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, regular_done, injected_conversion_done} = 4'h0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'h0;
        hsize = 3'h2;
        {regular_channel, injected_channel, injected_rank} = 12'h000;
        {regular_data, injected_data} = 32'h0000_0000;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk("ctrl reset", OFS_CTRL, 32'h0000_0000);
        rd_chk("cfg reset", OFS_CFG, 32'h0000_0000);
        rd_chk("unmapped", 8'h3c, 32'h0000_0000);
        check("hresp", {31'h0, hresp}, 32'h0000_0000);
        $display("test reset done");
        // writes allowed while on as well as off
        wr(OFS_DIFF, 32'h0000_00a5);
        @(negedge hclk);
        check("diff out", {16'h0000, differential_select}, 32'h0000_00a5);
        wr(OFS_CTRL, 32'h0000_0002);
        @(negedge hclk);
        check("cal pulse", {25'h0, ctl_o}, 32'h0000_0002);
        @(negedge hclk);
        check("cal clear", {25'h0, ctl_o}, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 2; i++) begin
            wr(OFS_CTRL, 32'h1 | (32'h4 << i));
            @(negedge hclk);
            check("start out", {25'h0, ctl_o}, 32'h1 | (32'h4 << i));
            wr(OFS_JSEQ, 32'hdead_beef + i);
            rd_chk("jseq busy", OFS_JSEQ, 32'hdead_beef + i);
            wr(OFS_CTRL, 32'h1 | (32'h10 << i));
            @(negedge hclk);
            check("stop out", {25'h0, ctl_o}, 32'h1 | (32'h4 << i) | (32'h10 << i));
            rd_chk("stop clears", OFS_CTRL, 32'h0000_0001);
        end
        $display("test start stop done");
        // formatting, offsets and interrupt
        wr(OFS_MASK, 32'h0000_0001);
        wr(OFS_SLOT0, 32'h8c00_0100);
        wr(OFS_SLOT0 + 8'h04, 32'h9400_0400);
        rd_chk("slot read", OFS_SLOT0, 32'h8c00_0100);
        for (int i = 0; i < 10; i++) begin
            wr(OFS_CFG, {24'h0, tv[i][47:40]});
            conv(1'b0, tv[i][36:32], tv[i][31:16], 2'h0);
            rd_chk("result", OFS_RRES, {16'h0, tv[i][15:0]});
        end
        wr(OFS_CFG, 32'h0000_0000);
        conv(1'b1, 5'h04, 16'h0123, 2'h2);
        rd_chk("inj rank2", OFS_JRES0 + 8'h08, 32'h0000_0123);
        rd_chk("inj rank0", OFS_JRES0, 32'h0000_0000);
        rd_chk("status", OFS_STAT, 32'h0000_0003);
        check("irq set", {31'h0, irq}, 32'h0000_0001);
        wr(OFS_STAT, 32'h0000_0001);
        rd_chk("status w1c", OFS_STAT, 32'h0000_0002);
        check("irq masked", {31'h0, irq}, 32'h0000_0000);
        wr(OFS_MASK, 32'h0000_0002);
        @(negedge hclk);
        @(negedge hclk);
        check("irq inj", {31'h0, irq}, 32'h0000_0001);
        wr(OFS_STAT, 32'h0000_0002);
        @(negedge hclk);
        @(negedge hclk);
        check("irq clear", {31'h0, irq}, 32'h0000_0000);
        $display("test results done");
        // disable request and recovery
        wr(OFS_CTRL, 32'h0000_0041);
        @(negedge hclk);
        @(negedge hclk);
        check("disable", {25'h0, ctl_o}, 32'h0000_0000);
        conv(1'b0, 5'h04, 16'h0555, 2'h0);
        rd_chk("off event", OFS_STAT, 32'h0000_0000);
        rd_chk("off result", OFS_RRES, 32'h0000_ffff);
        wr(OFS_CTRL, 32'h0000_003f);
        wr(OFS_CTRL, 32'h0000_0000);
        @(negedge hclk);
        check("recover", {25'h0, ctl_o}, 32'h0000_0000);
        $display("test disable done");
        finish_test();
    end

    initial begin
        repeat (4000) @(posedge hclk);
        mismatches++;
        finish_test();
    end
endmodule : tb_adcc_ctrl
`default_nettype wire
